// ==== logic/ccd_top.sv ====
// channel clock dividers: three single-stage and two cascaded channels
// assumes vco_in / ext_in are sampled levels synchronous to mclk, AXI4-Lite master
//
// Behaviour
// R01 - each stage: low for low+1, high for high+1 input cycles
// R02 - stages count cycles of the clock routed to the divider input
// R03 - bypass set passes the input, divide by one
// R04 - unbypassed stage divides by high plus low plus two
// R05 - correction on by default, disabled per channel by its disable bit
// R06 - correction forces 50%; software sets matching counts
// R07 - uncorrected duty equals (high+1) over the total division
// R08 - corrected odd ratio extends high by half an input cycle
// R09 - direct routing keeps the source's own duty cycle
// R10 - phase offset delays first rising edge by whole input cycles
// R11 - offset value is start_high*16 plus phase_offset; below 16 delay equals it
// R12 - with start_high, delay is value minus 16 plus low plus one
// R13 - offsets take effect only after a realign
// R14 - channels 3 and 4 cascade two stages, product up to 1024
// R15 - both bypassed gives one, second bypassed gives first ratio
// R16 - software uses first stage alone, never second alone
// R17 - one disable bit turns correction off for both cascaded stages
// R18 - channel 3 second stage counts in own register, bypass at bit 5
// R19 - second single-ended outputs of channels 3, 4 off after reset
// R20 - oscillator divider divides by 2 to 6
// R21 - each output may begin high after realign; cascaded outputs 3 and 4 have sh tied to 0 and begin low
// R22 - counts and bypass are applied at the next realign
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ccd_map.svh"
module ccd_top (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                vco_in,
  input  wire logic                ext_in,
  output      logic [4:0]          clk_out,
  output      logic [1:0]          b_out_en
);
  import ccd_pkg::*;

  localparam logic [9:0] IDX [`CCD_NREG] = `CCD_IDX_LIST;

  // hit flag above a 5-bit slot number
  function automatic logic [5:0] slot_of(input logic [9:0] idx);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < `CCD_NREG; i++) begin
      if (IDX[i] == idx) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  ccd_byte_t  regs [`CCD_NREG];
  logic       aw_got;
  logic       w_got;
  logic [9:0] aw_idx;
  ccd_byte_t  w_byte;
  logic       w_lane;
  logic       boot;
  logic       realign;

  // ---------------- AXI4-Lite write path ----------------
  wire        aw_take      = s_axi_awvalid & s_axi_awready;
  wire        w_take       = s_axi_wvalid & s_axi_wready;
  wire        do_wr        = aw_got & w_got;
  wire        next_aw_got  = aw_take | (aw_got & ~do_wr);
  wire        next_w_got   = w_take | (w_got & ~do_wr);
  wire        next_bvalid  = do_wr | (s_axi_bvalid & ~s_axi_bready);
  wire [5:0]  wr_slot      = slot_of(aw_idx);
  wire        wr_ok        = wr_slot[5] && wr_slot[4:0] != 5'(`CCD_S_STAT);
  wire        wr_en        = do_wr & wr_ok & w_lane;
  wire        wr_ctl       = wr_en && wr_slot[4:0] == 5'(`CCD_S_CTL);
  wire        next_realign = boot | (wr_ctl & w_byte[`CCD_F_REALN]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_idx        <= 10'h000;
      w_byte        <= 8'h00;
      w_lane        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCD_RESP_OK;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready  <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_take) begin
        aw_idx <= s_axi_awaddr[11:2];
      end
      if (w_take) begin
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        s_axi_bresp <= wr_slot[5] ? `CCD_RESP_OK : `CCD_RESP_ERR;
      end
    end
  end

  // register store; all fields clear at reset, so B outputs start off
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < `CCD_NREG; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (wr_en) begin
      regs[wr_slot[4:0]] <= w_byte;
    end
  end

  // realign after reset, then on each write of the realign bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot    <= 1'b1;
      realign <= 1'b0;
    end else begin
      boot    <= 1'b0;
      realign <= next_realign; // R13
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  wire        ar_take     = s_axi_arvalid & s_axi_arready;
  wire        next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [5:0]  rd_slot     = slot_of(s_axi_araddr[11:2]);
  wire        rd_stat     = rd_slot[4:0] == 5'(`CCD_S_STAT);
  wire ccd_byte_t rd_byte = rd_stat ? {3'h0, clk_out} : regs[rd_slot[4:0]];

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CCD_RESP_OK;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_slot[5] ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        s_axi_rresp <= rd_slot[5] ? `CCD_RESP_OK : `CCD_RESP_ERR;
      end
    end
  end

  // ---------------- oscillator divider and source routing ----------------
  wire [1:0] src_sel  = regs[`CCD_S_SRC][`CCD_F_SRC];
  wire [2:0] vdiv_raw = regs[`CCD_S_VDIV][`CCD_F_VDIV];
  // out-of-range codes fall back to the smallest ratio
  wire       vdiv_ok  = vdiv_raw >= `CCD_VDIV_MIN && vdiv_raw <= `CCD_VDIV_MAX;
  wire [2:0] vdiv     = vdiv_ok ? vdiv_raw : `CCD_VDIV_MIN;
  wire       pre_in   = (src_sel == `CCD_SRC_VCO) ? vco_in : ext_in;
  logic       pre_prev;
  logic       pre_lvl;
  logic [2:0] pcnt;
  wire        pre_rise  = pre_in & ~pre_prev;
  wire        pcnt_wrap = pcnt >= vdiv - 3'h1;
  wire [2:0]  next_pcnt = pcnt_wrap ? 3'h0 : pcnt + 3'h1;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_prev <= 1'b0;
      pcnt     <= 3'h0;
      pre_lvl  <= 1'b0;
    end else begin
      pre_prev <= pre_in;
      if (pre_rise) begin
        pcnt    <= next_pcnt; // R20
        pre_lvl <= next_pcnt < (vdiv >> 1); // R20
      end
    end
  end

  // direct external routing keeps its duty; the vco path uses the divider's
  wire src_lvl = (src_sel == `CCD_SRC_EXTD) ? ext_in : pre_lvl; // R02 R09

  // ---------------- divider stages ----------------
  // stages 0-2 single channels, 3-4 first stages, 5-6 second stages
  logic [6:0] st_out;

  for (genvar s = 0; s < 7; s++) begin : g_st
    localparam int BANK = (s == 3 || s == 5) ? `CCD_S_CH3 : `CCD_S_CH4;
    localparam int CNT  = (s < 5) ? BANK : BANK + `CCD_O_CNT2;
    ccd_stage_cfg_s cfg_w;
    ccd_stage_cfg_s acfg;
    ccd_phase_e     ph;
    logic [3:0]     cnt;
    logic [4:0]     dly;
    logic           q;
    logic           pend;
    logic           in_prev;
    wire            in_lvl;

    if (s < 3) begin : g_single
      localparam int B = `CCD_S_CH0 + `CCD_CH_STEP * s;
      assign cfg_w = '{low:     regs[B][`CCD_F_LOW],
                       high:    regs[B][`CCD_F_HIGH],
                       byp:     regs[B + 1][`CCD_F_BYP],
                       dcc_off: regs[B + 2][`CCD_F_DUTY_CORRECT_DISABLE], // R05
                       sh:      regs[B + 1][`CCD_F_SH],
                       po:      regs[B + 1][`CCD_F_PO]};
      assign in_lvl = src_lvl;
    end else begin : g_casc
      // one disable bit serves both stages of the channel
      assign cfg_w = '{low:     regs[CNT][`CCD_F_LOW], // R18
                       high:    regs[CNT][`CCD_F_HIGH], // R18
                       byp:     (s < 5) ? regs[BANK + `CCD_O_BYP][`CCD_F_BYP1]
                                        : regs[BANK + `CCD_O_BYP][`CCD_F_BYP2], // R18
                       dcc_off: regs[BANK + `CCD_O_DCC][`CCD_F_DUTY_CORRECT_DISABLE], // R17
                       sh:      1'b0,
                       po:      4'h0};
      if (s < 5) begin : g_first
        assign in_lvl = src_lvl;
      end else begin : g_second
        assign in_lvl = st_out[s - 2]; // R14
      end
    end

    wire       rise    = in_lvl & ~in_prev;
    wire       fall    = ~in_lvl & in_prev;
    wire       odd_dcc = ~acfg.dcc_off && {1'b0, acfg.low} == {1'b0, acfg.high} + 5'h01;
    wire [4:0] dly0    = cfg_w.sh ? {1'b0, cfg_w.po} + {1'b0, cfg_w.low} + 5'h01
                                  : {1'b0, cfg_w.po};

    // bypass gives divide by one; cascade bypass passes stage one through
    assign st_out[s] = acfg.byp ? in_lvl : q; // R03 R15

    always_ff @(posedge mclk) begin
      if (rst) begin
        acfg    <= '0;
        ph      <= PH_WAIT;
        cnt     <= 4'h0;
        dly     <= 5'h00;
        q       <= 1'b0;
        pend    <= 1'b0;
        in_prev <= 1'b0;
      end else begin
        in_prev <= in_lvl;
        if (realign) begin
          acfg <= cfg_w; // R22
          ph   <= PH_WAIT;
          dly  <= dly0; // R11 R12
          q    <= cfg_w.sh; // R21
          pend <= 1'b0;
        end else if (rise && !acfg.byp) begin
          case (ph)
            PH_WAIT: begin
              if (dly == 5'h00) begin
                q   <= 1'b1; // R10
                cnt <= acfg.high;
                ph  <= PH_HIGH;
              end else begin
                dly <= dly - 5'h01;
                q   <= 1'b0;
              end
            end
            PH_HIGH: begin
              if (cnt == 4'h0) begin
                // odd ratio under correction: fall half a cycle later
                pend <= odd_dcc; // R06 R08
                q    <= odd_dcc; // R07
                cnt  <= acfg.low; // R01 R04
                ph   <= PH_LOW;
              end else begin
                cnt <= cnt - 4'h1; // R01
              end
            end
            PH_LOW: begin
              if (cnt == 4'h0) begin
                q   <= 1'b1;
                cnt <= acfg.high; // R01 R04
                ph  <= PH_HIGH;
              end else begin
                cnt <= cnt - 4'h1; // R01
              end
            end
            default: ph <= PH_WAIT;
          endcase
        end else if (fall && pend) begin
          q    <= 1'b0; // R06
          pend <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_out  <= 5'h00;
      b_out_en <= 2'h0;
    end else begin
      clk_out  <= {st_out[6], st_out[5], st_out[2:0]}; // R14 R15
      b_out_en <= regs[`CCD_S_CTL][`CCD_F_BEN]; // R19
    end
  end

endmodule

// ==== logic/ccd_map.svh ====
// register indices, slots and field positions of the channel clock dividers
// assumes byte address = 4 * index on the AXI4-Lite bus
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH
`define CCD_IDX_LIST '{10'h190, 10'h191, 10'h192, 10'h193, 10'h194, 10'h195, \
  10'h196, 10'h197, 10'h198, 10'h199, 10'h19b, 10'h19c, 10'h19d, 10'h19e, 10'h1a0, \
  10'h1a1, 10'h1a2, 10'h1e0, 10'h1e1, 10'h1f0, 10'h1f1}
`define CCD_NREG     21
`define CCD_S_CH0    0
`define CCD_CH_STEP  3
`define CCD_S_CH3    9
`define CCD_S_CH4    13
`define CCD_O_CNT2   1
`define CCD_O_BYP    2
`define CCD_O_DCC    3
`define CCD_S_VDIV   17
`define CCD_S_SRC    18
`define CCD_S_CTL    19
`define CCD_S_STAT   20
`define CCD_F_LOW    7:4
`define CCD_F_HIGH   3:0
`define CCD_F_BYP    7
`define CCD_F_SH     4
`define CCD_F_PO     3:0
`define CCD_F_BYP1   4
`define CCD_F_BYP2   5
`define CCD_F_DUTY_CORRECT_DISABLE 0
`define CCD_F_VDIV   2:0
`define CCD_F_SRC    1:0
`define CCD_F_REALN  0
`define CCD_F_BEN    2:1
`define CCD_SRC_EXTD 2'b01
`define CCD_SRC_VCO  2'b10
`define CCD_VDIV_MIN 3'h2
`define CCD_VDIV_MAX 3'h6
`define CCD_RESP_OK  2'b00
`define CCD_RESP_ERR 2'b10
`endif

// ==== logic/ccd_pkg.sv ====
// types shared by the channel clock divider block
// assumes ccd_map.svh for all numeric constants
package ccd_pkg;
  typedef enum logic [1:0] {PH_WAIT, PH_HIGH, PH_LOW} ccd_phase_e;
  typedef struct packed {
    logic [3:0] low;
    logic [3:0] high;
    logic       byp;
    logic       dcc_off;
    logic       sh;
    logic [3:0] po;
  } ccd_stage_cfg_s;
  typedef logic [7:0] ccd_byte_t;
endpackage

// ==== tb/ccd_top_sva.sv ====
// register bus and output-enable assertions for ccd_top
// assumes one clock mclk and a synchronous active-high rst
`timescale 1ns/1ps
module ccd_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  b_out_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_refused: assert property (s_wr_taken |=> (!s_axi_awready && !s_axi_wready) [*2])
    else $error("write taken again too soon");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_ben_reset: assert property (@(posedge mclk) disable iff (1'b0) rst |=> b_out_en == 2'b00)
    else $error("second outputs on after reset");
endmodule
bind ccd_top ccd_chk ccd_chk_i (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .b_out_en);

// ==== tb/tb_channel_clock_dividers.sv ====
// self-checking bench for the channel clock dividers
// assumes byte address 4 * index; source clocks come from one mclk counter
`timescale 1ns/1ps
`include "ccd_map.svh"
module tb_channel_clock_dividers;
  logic        mclk = '0, rst = 1'b1, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        vco_in, ext_in;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0, in_cnt = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, b_out_en;
  logic [4:0]  clk_out;
  int          bad_count = 0, n_tests = 0, cyc = 0, h, l;
  localparam logic [1:0] OK = `CCD_RESP_OK;
  ccd_top ccd_top_i (.*);
  // ext period 4 mclk, vco period 8 mclk
  assign vco_in = in_cnt[2];
  assign ext_in = in_cnt[1];
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    in_cnt <= in_cnt + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a = 1'b0, w = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge mclk);
      a |= s_axi_awready;
      w |= s_axi_wready;
      s_axi_awvalid <= !a;
      s_axi_wvalid <= !w;
    end
    // bready stands from the request; the answer is taken at the edge it is seen
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h00_0000, d});
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic realign();
    wr(10'h1f0, 8'h01, OK);
  endtask
  // first period after a realign is skipped
  task automatic meas(input int ch, output int hi, output int lo);
    repeat (2) begin
      do @(posedge mclk); while (clk_out[ch] !== 1'b0);
      do @(posedge mclk); while (clk_out[ch] !== 1'b1);
      hi = 0;
      lo = 0;
      while (clk_out[ch] === 1'b1) begin
        @(posedge mclk);
        hi++;
      end
      while (clk_out[ch] === 1'b0) begin
        @(posedge mclk);
        lo++;
      end
    end
  endtask
  task automatic skew(output int k);
    repeat (70) @(posedge mclk);
    do @(posedge mclk); while (clk_out[0] !== 1'b0);
    do @(posedge mclk); while (clk_out[0] !== 1'b1);
    k = 0;
    while (clk_out[1] !== 1'b1) begin
      @(posedge mclk);
      k++;
    end
  endtask
  task automatic t_ben();
    chk(32'(b_out_en), 32'h0);
    wr(10'h1f0, 8'h06, OK);
    // enables are registered one edge after the store
    @(posedge mclk);
    chk(32'(b_out_en), 32'h3);
    rd(10'h1f0, 8'h06, OK);
    $display("second output enables done");
  endtask
  task automatic t_regs();
    logic [9:0] idx [17] = '{10'h190, 10'h191, 10'h192, 10'h193, 10'h194, 10'h195, 10'h196,
      10'h197, 10'h198, 10'h199, 10'h19b, 10'h19c, 10'h19d, 10'h19e, 10'h1a0, 10'h1a1, 10'h1a2};
    foreach (idx[i]) begin
      rd(idx[i], 8'h00, OK);
      wr(idx[i], 8'ha5, OK);
      rd(idx[i], 8'ha5, OK);
      wr(idx[i], 8'h00, OK);
    end
    rd(10'h1a3, 8'h00, `CCD_RESP_ERR);
    wr(10'h1a3, 8'h5a, `CCD_RESP_ERR);
    wr(10'h1f1, 8'hff, OK);
    $display("registers done");
  endtask
  task automatic t_div();
    // correction off flag, low count, high count
    logic [8:0] cfg [6] = '{9'h100, 9'h1ff, 9'h152, 9'h131, 9'h032, 9'h1f0};
    int c;
    wr(10'h1e1, 8'h01, OK);
    foreach (cfg[i]) begin
      wr(10'h190, cfg[i][7:0], OK);
      wr(10'h192, {7'h00, cfg[i][8]}, OK);
      realign();
      c = (!cfg[i][8] && cfg[i][7:4] == cfg[i][3:0] + 4'h1) ? 2 : 0;
      meas(0, h, l);
      chk(h, 4 * cfg[i][3:0] + 4 + c);
      chk(l, 4 * cfg[i][7:4] + 4 - c);
    end
    $display("single-stage ratios done");
  endtask
  task automatic t_byp();
    wr(10'h191, 8'h80, OK);
    for (int d = 0; d < 2; d++) begin
      wr(10'h192, 8'(d), OK);
      realign();
      meas(0, h, l);
      chk(h, 2);
      chk(l, 2);
    end
    wr(10'h191, 8'h00, OK);
    $display("bypass done");
  endtask
  task automatic t_src();
    logic [7:0] src [3] = '{8'h02, 8'h02, 8'h00};
    logic [7:0] rat [3] = '{8'h02, 8'h06, 8'h02};
    int hv [3] = '{16, 48, 8};
    wr(10'h190, 8'h00, OK);
    foreach (src[i]) begin
      wr(10'h1e1, src[i], OK);
      wr(10'h1e0, rat[i], OK);
      realign();
      meas(0, h, l);
      chk(h, hv[i]);
      chk(l, hv[i]);
    end
    wr(10'h1e1, 8'h01, OK);
    $display("sources done");
  endtask
  task automatic t_casc();
    logic [9:0] base [2] = '{10'h199, 10'h19e};
    logic [1:0] byp [3] = '{2'b11, 2'b10, 2'b00};
    int hv [3] = '{2, 4, 16};
    foreach (base[c]) begin
      wr(base[c], 8'h00, OK);
      wr(base[c] + 10'h2, 8'h11, OK);
      foreach (byp[i]) begin
        wr(base[c] + 10'h3, {2'b00, byp[i], 4'h0}, OK);
        realign();
        meas(3 + c, h, l);
        chk(h, hv[i]);
        chk(l, hv[i]);
      end
    end
    $display("cascaded channels done");
  endtask
  task automatic t_phase();
    wr(10'h190, 8'h77, OK);
    wr(10'h193, 8'h77, OK);
    realign();
    skew(h);
    chk(h, 0);
    wr(10'h194, 8'h03, OK);
    skew(h);
    chk(h, 0);
    realign();
    skew(h);
    chk(h, 12);
    wr(10'h194, 8'h10, OK);
    realign();
    skew(h);
    chk(h, 32);
    $display("phase offsets done");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_ben();
    t_regs();
    t_div();
    t_byp();
    t_src();
    t_casc();
    t_phase();
    final_report();
  end
endmodule
